// *** core/nand_host_pkg.sv ***
// constants and carriers shared by the nand host sequencer
// assumes one 125 MHz clock domain on the controller side
package nand_host_pkg;
  // command codes on the data pins
  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_READ_COPY    = 8'h35;
  localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_CFM = 8'he0;
  localparam logic [7:0] CMD_SERIAL_IN    = 8'h80;
  localparam logic [7:0] CMD_RAND_IN      = 8'h85;
  localparam logic [7:0] CMD_PLANE_IN     = 8'h81;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_DUMMY_CFM    = 8'h11;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
  localparam logic [7:0] CMD_ERASE_CFM    = 8'hd0;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_RESET        = 8'hff;
  // status bit positions
  localparam int STATUS_READY_BIT = 6;
  localparam int STATUS_FAIL_BIT  = 0;
  // geometry
  localparam logic [11:0] PAGE_BYTES      = 12'h840;
  localparam logic [2:0]  ADDR_CYCLES     = 3'h5;
  localparam logic [2:0]  ROW_CYCLES      = 3'h3;
  localparam logic [1:0]  COL_CYCLES      = 2'h2;
  // strobe timing: each strobe phase low then high
  localparam int CLK_PERIOD_NS    = 8;
  localparam int STROBE_PHASE_NS  = 16;
  localparam logic [3:0] STROBE_PHASE_CYC =
    4'((STROBE_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // wait after a confirm before ready/busy is trusted
  localparam int BUSY_SETTLE_NS   = 100;
  localparam logic [3:0] BUSY_SETTLE_CYC =
    4'((BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    OP_READ, OP_RAND_OUT, OP_PROGRAM, OP_RAND_IN, OP_COPY_READ,
    OP_COPY_PROG, OP_ERASE, OP_STATUS
  } op_t;

  // one request from the user side
  typedef struct packed {
    op_t         op;
    logic        two_plane;  // program: close first plane with dummy confirm
    logic [11:0] column;
    logic [17:0] row;
    logic [17:0] row2;       // second plane row, same except plane bit
    logic [11:0] count;      // bytes to move
  } req_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       write_strobe_n;
    logic       output_strobe_n;
  } ctrl_t;
endpackage

// *** core/nand_host_seq.sv ***
// nand host sequencer: drives command, address and data cycles to the flash
// assumes flash pins are asynchronous; one clock, one chip select held low
`timescale 1ns/1ns
// Function
// [R1] read: setup 00h, five address cycles, confirm 30h
// [R2] after read confirm wait for ready before reading data
// [R3] read bytes one per output strobe falling edge from the column
// [R4] random output: 05h, two column cycles, e0h, then continue
// [R5] program: 80h, five address cycles, then up to 2112 data bytes
// [R6] random data input: 85h and column cycles redirect following bytes
// [R7] confirm 10h is only issued after data was loaded
// [R8] while busy, issue only read status or reset
// [R9] completion taken from ready pin; pass/fail from status bit 0
// [R10] fail bit reports only unprogrammed ones; passed to user unchanged
// [R11] after program, device stays in status mode; reissue 00h to read
// [R12] user keeps pages programmed once and in order within block
// [R13] copy-back: 00h addr 35h, then 85h destination address, 10h
// [R14] user keeps copy-back source and destination in one plane
// [R15] copy-back may modify buffer with random data input before confirm
// [R16] erase: 60h, three row cycles, d0h
// [R17] erase sends only row cycles; low page bits are ignored by device
// [R18] two-plane program may use different blocks, same page
// [R19] two-plane: 11h closes plane one, 81h starts plane two, 10h
// [R20] combined fail bit reported once for both planes
// [R21] between 11h and 81h only status polling is issued
// [R22] second plane row given by user, differing only in plane bit
// [R23] status byte read repeatedly without new strobes is allowed
// [R24] after status during read, reissue 00h before data reads
// [R25] ready/busy low during every internal operation is waited out
module nand_host_seq (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_req_valid,
  input  wire nand_host_pkg::req_t  i_req,
  output logic                      o_req_ready,
  input  wire logic                 i_wdata_valid,
  input  wire logic [7:0]           i_wdata,
  output logic                      o_wdata_ready,
  output logic                      o_rdata_valid,
  output logic [7:0]                o_rdata,
  input  wire logic                 i_rdata_ready,
  output logic                      o_done,
  output logic                      o_fail,
  output logic                      o_cle,
  output logic                      o_ale,
  output logic                      o_write_strobe_n,
  output logic                      o_output_strobe_n,
  output logic [7:0]                o_dq,
  output logic                      o_dq_oe_n,
  input  wire logic [7:0]           i_dq,
  input  wire logic                 i_ready_busy
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR, S_WDATA, S_RDATA, S_WAIT, S_POLL, S_FINISH
  } state_t;

  state_t               state;
  nand_host_pkg::req_t  req;
  logic [3:0]           step;      // sequence step within the operation
  logic [2:0]           addr_idx;
  logic [2:0]           addr_last;
  logic [11:0]          byte_cnt;
  logic [3:0]           phase_cnt;
  logic                 phase_hi;  // second half of a strobe cycle
  logic [3:0]           settle_cnt;
  logic                 loaded;
  logic                 plane2;
  logic [7:0]           cmd;
  logic [1:0]           rb_sync;
  logic [7:0]           dq_s1;
  logic [7:0]           dq_s2;
  // two-entry read buffer
  logic [7:0]           buf_data [2];
  logic                 wr_ptr;
  logic                 rd_ptr;
  logic [1:0]           buf_cnt;
  logic                 buf_push;
  logic                 buf_pop;
  logic                 tick;
  logic [7:0]           addr_byte;
  logic [17:0]          row_sel;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rb_sync <= 2'h0;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
    end
    else
    begin
      rb_sync <= {rb_sync[0], i_ready_busy};
      dq_s1   <= i_dq;
      dq_s2   <= dq_s1;
    end
  end

  // strobe half-cycle timer; wide phases meet the 25ns cycle with margin
  assign tick = (phase_cnt == nand_host_pkg::STROBE_PHASE_CYC - 4'h1);
  assign row_sel = plane2 ? req.row2 : req.row; // [R22]

  always_comb
  begin
    if (addr_idx == 3'h0)
      addr_byte = req.column[7:0];
    else if (addr_idx == 3'h1)
      addr_byte = {4'h0, req.column[11:8]};
    else if (addr_idx == 3'h2)
      addr_byte = row_sel[7:0];
    else if (addr_idx == 3'h3)
      addr_byte = row_sel[15:8];
    else
      addr_byte = {6'h00, row_sel[17:16]};
  end

  assign buf_pop  = o_rdata_valid && i_rdata_ready;
  // a sample is only taken when the buffer has room, so no byte is lost
  assign buf_push = (state == S_RDATA) && phase_hi && tick && (buf_cnt != 2'h2);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
      buf_data[0] <= 8'h00;
      buf_data[1] <= 8'h00;
    end
    else
    begin
      if (buf_push)
      begin
        buf_data[wr_ptr] <= dq_s2; // [R3]
        wr_ptr <= ~wr_ptr;
      end
      if (buf_pop)
        rd_ptr <= ~rd_ptr;
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata_valid <= 1'b0;
      o_rdata       <= 8'h00;
    end
    else
    begin
      o_rdata_valid <= (buf_cnt != 2'h0) && !(buf_pop && buf_cnt == 2'h1)
                       || buf_push;
      if (buf_cnt == 2'h0 || buf_pop)
        o_rdata <= (buf_cnt == 2'h2) ? buf_data[~rd_ptr] : dq_s2;
      else
        o_rdata <= buf_data[rd_ptr];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= S_IDLE;
      req <= '0;
      step <= 4'h0;
      addr_idx <= 3'h0;
      addr_last <= 3'h0;
      byte_cnt <= 12'h000;
      phase_cnt <= 4'h0;
      phase_hi <= 1'b0;
      settle_cnt <= 4'h0;
      loaded <= 1'b0;
      plane2 <= 1'b0;
      cmd <= 8'h00;
      o_req_ready <= 1'b1;
      o_wdata_ready <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_write_strobe_n <= 1'b1;
      o_output_strobe_n <= 1'b1;
      o_dq <= 8'h00;
      o_dq_oe_n <= 1'b1;
    end
    else
    begin
      o_done <= 1'b0;
      o_wdata_ready <= 1'b0;
      phase_cnt <= tick ? 4'h0 : phase_cnt + 4'h1;
      case (state)
        S_IDLE:
        begin
          phase_cnt <= 4'h0;
          phase_hi <= 1'b0;
          if (i_req_valid)
          begin
            req <= i_req; // [R12] [R14] as given
            o_req_ready <= 1'b0;
            step <= 4'h0;
            loaded <= 1'b0;
            plane2 <= 1'b0;
            state <= S_FINISH; // dispatch through the step table below
          end
        end
        S_CMD:
        begin
          o_cle <= 1'b1;
          o_dq <= cmd;
          o_dq_oe_n <= 1'b0;
          o_write_strobe_n <= phase_hi;
          if (tick)
          begin
            phase_hi <= ~phase_hi;
            if (phase_hi)
            begin
              o_cle <= 1'b0;
              step <= step + 4'h1;
              state <= S_FINISH;
            end
          end
        end
        S_ADDR:
        begin
          o_ale <= 1'b1;
          o_dq <= addr_byte;
          o_dq_oe_n <= 1'b0;
          o_write_strobe_n <= phase_hi;
          if (tick)
          begin
            phase_hi <= ~phase_hi;
            if (phase_hi)
            begin
              addr_idx <= addr_idx + 3'h1;
              if (addr_idx == addr_last)
              begin
                o_ale <= 1'b0;
                step <= step + 4'h1;
                state <= S_FINISH;
              end
            end
          end
        end
        S_WDATA:
        begin
          o_dq_oe_n <= 1'b0;
          if (!phase_hi && byte_cnt == 12'h000)
          begin
            step <= step + 4'h1;
            state <= S_FINISH;
          end
          else if (!phase_hi && phase_cnt == 4'h0 && !i_wdata_valid)
            phase_cnt <= 4'h0; // source stall holds the strobe high
          else
          begin
            if (!phase_hi && phase_cnt == 4'h0)
            begin
              o_dq <= i_wdata;
              o_wdata_ready <= 1'b1;
              loaded <= 1'b1; // [R5]
            end
            o_write_strobe_n <= phase_hi;
            if (tick)
            begin
              phase_hi <= ~phase_hi;
              if (phase_hi)
                byte_cnt <= byte_cnt - 12'h001;
            end
          end
        end
        S_RDATA:
        begin
          o_dq_oe_n <= 1'b1;
          if (!phase_hi && byte_cnt == 12'h000)
          begin
            step <= step + 4'h1;
            state <= S_FINISH;
          end
          else if (!phase_hi && phase_cnt == 4'h0 && buf_cnt == 2'h2)
            phase_cnt <= 4'h0; // full buffer holds the strobe high
          else
          begin
            o_output_strobe_n <= phase_hi; // [R3]
            if (tick)
            begin
              phase_hi <= ~phase_hi;
              if (phase_hi)
              begin
                o_output_strobe_n <= 1'b1;
                byte_cnt <= byte_cnt - 12'h001;
              end
            end
          end
        end
        S_WAIT:
        begin
          // ready/busy falls a little after the confirm; do not trust it yet
          o_dq_oe_n <= 1'b1;
          if (settle_cnt != nand_host_pkg::BUSY_SETTLE_CYC)
            settle_cnt <= settle_cnt + 4'h1;
          else if (rb_sync[1]) // [R2] [R25] [R8]
          begin
            step <= step + 4'h1;
            state <= S_FINISH;
          end
        end
        S_POLL:
        begin
          // status byte stays on the pins while the strobe is held low
          o_dq_oe_n <= 1'b1;
          o_output_strobe_n <= 1'b0; // [R23]
          phase_hi <= phase_hi | tick; // first tick still sees the old bus
          if (tick && phase_hi)
          begin
            o_fail <= dq_s2[nand_host_pkg::STATUS_FAIL_BIT]; // [R9] [R10] [R20]
            if (dq_s2[nand_host_pkg::STATUS_READY_BIT])
            begin
              o_output_strobe_n <= 1'b1;
              step <= step + 4'h1;
              state <= S_FINISH;
            end
          end
        end
        default:
        begin
          // step table: command, address, data, wait per operation
          phase_cnt <= 4'h0;
          phase_hi <= 1'b0;
          settle_cnt <= 4'h0;
          addr_idx <= 3'h0;
          addr_last <= nand_host_pkg::ADDR_CYCLES - 3'h1;
          byte_cnt <= req.count;
          state <= S_CMD;
          case (req.op)
            nand_host_pkg::OP_READ, nand_host_pkg::OP_COPY_READ:
              case (step)
                4'h0: cmd <= nand_host_pkg::CMD_READ_SETUP; // [R1] [R24] [R11]
                4'h1: state <= S_ADDR;
                4'h2: cmd <= (req.op == nand_host_pkg::OP_READ) ?
                  nand_host_pkg::CMD_READ_CONFIRM : nand_host_pkg::CMD_READ_COPY; // [R13]
                4'h3: state <= S_WAIT;
                4'h4: cmd <= nand_host_pkg::CMD_READ_SETUP; // back to data output
                4'h5: state <= S_RDATA;
                default: state <= S_IDLE;
              endcase
            nand_host_pkg::OP_RAND_OUT:
              case (step)
                4'h0: cmd <= nand_host_pkg::CMD_RAND_OUT; // [R4]
                4'h1:
                begin
                  addr_last <= 3'(nand_host_pkg::COL_CYCLES) - 3'h1;
                  state <= S_ADDR;
                end
                4'h2: cmd <= nand_host_pkg::CMD_RAND_OUT_CFM;
                4'h3: state <= S_RDATA;
                default: state <= S_IDLE;
              endcase
            nand_host_pkg::OP_PROGRAM, nand_host_pkg::OP_COPY_PROG:
              case (step)
                4'h0: cmd <= (plane2) ? nand_host_pkg::CMD_PLANE_IN :
                  (req.op == nand_host_pkg::OP_PROGRAM) ? nand_host_pkg::CMD_SERIAL_IN :
                  nand_host_pkg::CMD_RAND_IN; // [R5] [R13] [R19]
                4'h1: state <= S_ADDR;
                4'h2:
                begin
                  state <= S_WDATA; // [R15] copy-back may load zero or more bytes
                  if (req.op == nand_host_pkg::OP_COPY_PROG)
                    loaded <= 1'b1;
                end
                4'h3:
                  if (!loaded)
                    state <= S_IDLE; // [R7]
                  else
                    cmd <= (req.two_plane && !plane2) ? nand_host_pkg::CMD_DUMMY_CFM :
                      nand_host_pkg::CMD_PROG_CONFIRM; // [R19] [R18]
                4'h4: state <= S_WAIT;
                4'h5:
                  if (req.two_plane && !plane2)
                  begin
                    plane2 <= 1'b1; // [R21] only the ready wait lies between
                    step <= 4'h0;
                    state <= S_FINISH;
                  end
                  else
                    cmd <= nand_host_pkg::CMD_READ_STATUS;
                4'h6: state <= S_POLL;
                default: state <= S_IDLE;
              endcase
            nand_host_pkg::OP_RAND_IN:
              case (step)
                4'h0: cmd <= nand_host_pkg::CMD_RAND_IN; // [R6]
                4'h1:
                begin
                  addr_last <= 3'(nand_host_pkg::COL_CYCLES) - 3'h1;
                  state <= S_ADDR;
                end
                4'h2: state <= S_WDATA;
                default: state <= S_IDLE;
              endcase
            nand_host_pkg::OP_ERASE:
              case (step)
                4'h0: cmd <= nand_host_pkg::CMD_ERASE_SETUP; // [R16]
                4'h1:
                begin
                  addr_idx <= 3'h2; // [R17]
                  state <= S_ADDR;
                end
                4'h2: cmd <= nand_host_pkg::CMD_ERASE_CFM;
                4'h3: state <= S_WAIT;
                4'h4: cmd <= nand_host_pkg::CMD_READ_STATUS;
                4'h5: state <= S_POLL;
                default: state <= S_IDLE;
              endcase
            default:
              case (step)
                4'h0: cmd <= nand_host_pkg::CMD_READ_STATUS;
                4'h1: state <= S_POLL;
                default: state <= S_IDLE;
              endcase
          endcase
          if (state == S_FINISH && (req.op == nand_host_pkg::OP_RAND_IN ? step > 4'h2 :
              req.op == nand_host_pkg::OP_RAND_OUT ? step > 4'h3 :
              req.op == nand_host_pkg::OP_STATUS ? step > 4'h1 :
              req.op == nand_host_pkg::OP_ERASE ? step > 4'h5 :
              (req.op == nand_host_pkg::OP_READ || req.op == nand_host_pkg::OP_COPY_READ) ?
              step > 4'h5 : (step > 4'h6 || (step == 4'h3 && !loaded))))
          begin
            o_done <= 1'b1;
            o_req_ready <= 1'b1;
            o_dq_oe_n <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule // nand_host_seq

// *** verification/nand_array_command_sequencer_bench.sv ***
// bench: host sequencer driving a behavioural flash through its pins
// assumes 125 MHz clock and the model's shortened busy times
`timescale 1ns/1ns
module nand_array_command_sequencer_bench;
  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic                req_valid = 1'b0;
  logic                rdata_ready = 1'b0;
  logic                fail_inject = 1'b0;
  logic [7:0]          wdata = 8'h00;
  nand_host_pkg::req_t req = '0;
  logic                req_ready, wready, rvalid, done, fail, cle, ale, ws_n, os_n, oe_n, rb;
  logic [7:0]          rdata, host_dq, flash_dq, dq_wire, base;
  logic [7:0]          rq [$];
  int                  bad_count, cmp_count, cyc, p;

  always #4 clk = ~clk;
  assign dq_wire = oe_n ? flash_dq : host_dq;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wready) wdata <= wdata + 8'h01;
    rdata_ready <= cyc % 3 != 0;  // periodic stall keeps the buffer busy
    if (rvalid && rdata_ready) rq.push_back(rdata);
    if (cyc == 80000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  nand_host_seq dut (
    .i_clk(clk), .i_resetn(resetn), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(req_ready), .i_wdata_valid(cyc % 5 != 0), .i_wdata(wdata),
    .o_wdata_ready(wready),
    .o_rdata_valid(rvalid), .o_rdata(rdata), .i_rdata_ready(rdata_ready), .o_done(done),
    .o_fail(fail), .o_cle(cle), .o_ale(ale), .o_write_strobe_n(ws_n),
    .o_output_strobe_n(os_n), .o_dq(host_dq), .o_dq_oe_n(oe_n), .i_dq(dq_wire),
    .i_ready_busy(rb)
  );
  nand_flash_model model (
    .i_clk(clk), .i_cle(cle), .i_ale(ale), .i_write_strobe_n(ws_n),
    .i_output_strobe_n(os_n), .i_dq(dq_wire), .i_fail_inject(fail_inject),
    .o_dq(flash_dq), .o_ready_busy(rb)
  );

  task automatic chk(string nm, logic [11:0] e, logic [11:0] s);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  task automatic run(nand_host_pkg::op_t op, logic two, logic [11:0] c, logic [17:0] r,
                     logic [17:0] r2, logic [11:0] n);
    int t;
    rq.delete();
    @(posedge clk);
    req <= '{op, two, c, r, r2, n};
    req_valid <= 1'b1;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    t = 0;
    do
    begin
      @(negedge clk);
      t++;
    end while (done !== 1'b1 && t < 20000);
    chk("done", 12'h001, {11'h000, done});
    repeat (6) @(posedge clk);  // let buffered bytes drain
  endtask

  task automatic chk_bytes(logic [7:0] first, logic [7:0] step, int n);
    chk("byte count", 12'(n), 12'(rq.size()));
    foreach (rq[i]) chk("read byte", {4'h0, first + 8'(i) * step}, {4'h0, rq[i]});
  endtask

  task automatic sc_program_read();
    base = wdata;
    p = model.progs;
    run(nand_host_pkg::OP_PROGRAM, 1'b0, 12'h010, 18'h00041, 18'h0, 12'h008);
    chk("fail", 12'h000, {11'h000, fail});
    chk("programs", 12'(p + 1), 12'(model.progs));
    run(nand_host_pkg::OP_READ, 1'b0, 12'h010, 18'h00041, 18'h0, 12'h008);
    chk_bytes(base, 8'h01, 8);
    run(nand_host_pkg::OP_RAND_OUT, 1'b0, 12'h014, 18'h00041, 18'h0, 12'h002);
    chk_bytes(base + 8'h04, 8'h01, 2);
  endtask

  task automatic sc_fail_copy();
    @(posedge clk) fail_inject <= 1'b1;
    run(nand_host_pkg::OP_PROGRAM, 1'b0, 12'h000, 18'h00042, 18'h0, 12'h004);
    run(nand_host_pkg::OP_STATUS, 1'b0, 12'h0, 18'h0, 18'h0, 12'h0);
    chk("fail", 12'h001, {11'h000, fail});
    fail_inject <= 1'b0;
    run(nand_host_pkg::OP_COPY_READ, 1'b0, 12'h000, 18'h00041, 18'h0, 12'h000);
    run(nand_host_pkg::OP_RAND_IN, 1'b0, 12'h018, 18'h0, 18'h0, 12'h002);
    run(nand_host_pkg::OP_COPY_PROG, 1'b0, 12'h000, 18'h00043, 18'h0, 12'h000);
    chk("fail", 12'h000, {11'h000, fail});
    run(nand_host_pkg::OP_READ, 1'b0, 12'h010, 18'h00043, 18'h0, 12'h008);
    chk_bytes(base, 8'h01, 8);
    run(nand_host_pkg::OP_RAND_OUT, 1'b0, 12'h018, 18'h0, 18'h0, 12'h002);
    chk_bytes(base + 8'h0c, 8'h01, 2);
  endtask

  task automatic sc_erase_zero();
    run(nand_host_pkg::OP_ERASE, 1'b0, 12'h000, 18'h00045, 18'h0, 12'h000);
    chk("erase address cycles", 12'h003, 12'(model.erase_an));
    run(nand_host_pkg::OP_READ, 1'b0, 12'h010, 18'h00041, 18'h0, 12'h004);
    chk_bytes(8'hff, 8'h00, 4);
    p = model.progs;
    run(nand_host_pkg::OP_PROGRAM, 1'b0, 12'h000, 18'h00040, 18'h0, 12'h000);
    chk("programs", 12'(p), 12'(model.progs));
  endtask

  task automatic sc_two_plane();
    base = wdata;
    // rows differ only in the plane bit
    run(nand_host_pkg::OP_PROGRAM, 1'b1, 12'h000, 18'h00080, 18'h000c0, 12'h004);
    chk("fail", 12'h000, {11'h000, fail});
    chk("protocol breaches", 12'h000, 12'(model.viol));
    run(nand_host_pkg::OP_READ, 1'b0, 12'h000, 18'h00080, 18'h0, 12'h004);
    chk_bytes(base, 8'h01, 4);
    run(nand_host_pkg::OP_READ, 1'b0, 12'h000, 18'h000c0, 18'h0, 12'h004);
    chk_bytes(base + 8'h04, 8'h01, 4);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    sc_program_read();
    sc_fail_copy();
    sc_erase_zero();
    sc_two_plane();
    print_verdict();
  end
endmodule // nand_array_command_sequencer_bench

// *** verification/nand_flash_model.sv ***
// behavioural flash device facing the host sequencer
// assumes i_clk paces its shortened busy times
`timescale 1ns/1ns
module nand_flash_model #(
  parameter int LOAD_CYC = 40,  // page_load_time, shortened
  parameter int PROG_CYC = 90,
  parameter int DBSY_CYC = 8    // plane_switch_busy_time
) (
  input  wire logic       i_clk,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_write_strobe_n,
  input  wire logic       i_output_strobe_n,
  input  wire logic [7:0] i_dq,
  input  wire logic       i_fail_inject,
  output logic [7:0]      o_dq,
  output logic            o_ready_busy
);
  logic [7:0] mem [int];
  logic [7:0] pbuf [0:2111];
  logic [7:0] cmd, rbyte, shown;
  logic [7:0] last = 8'h00;
  int         cyc, busy_end, col, row, an, sh, viol, progs, erase_an;
  int         ks [$];
  bit         stat_mode, loaded, fail, gap;

  always @(posedge i_clk) cyc <= cyc + 1;
  assign o_ready_busy = cyc >= busy_end;
  assign shown = stat_mode ? {1'b1, o_ready_busy, 5'h00, fail} : rbyte;
  // released bus shows the inverse of its last byte, never a stale copy
  assign o_dq = i_output_strobe_n ? ~last : shown;
  always @(posedge i_output_strobe_n) last = shown;
  always @(negedge i_output_strobe_n)
    if (!stat_mode && col < 2112)
    begin
      rbyte = pbuf[col];
      col++;
    end

  task automatic commit();
    foreach (pbuf[i]) if (pbuf[i] != 8'hff) mem[row * 4096 + i] = pbuf[i];
    fail |= i_fail_inject;  // one bit for both planes
    progs++;
  endtask

  always @(posedge i_write_strobe_n)
    if (i_cle)
    begin
      if (!(i_dq inside {8'h70, 8'hff}) && (!o_ready_busy || gap && i_dq != 8'h81))
        viol++;
      stat_mode = i_dq == 8'h70;
      if (!stat_mode) cmd = i_dq;
      if (i_dq == 8'hd0) erase_an = an;
      an = 0;
      case (i_dq)
        8'h80, 8'h81:
        begin
          foreach (pbuf[i]) pbuf[i] = 8'hff;
          loaded = 0;
          gap = 0;
          fail &= i_dq == 8'h81;
        end
        8'h30, 8'h35:
        begin
          foreach (pbuf[i]) pbuf[i] = mem.exists(row * 4096 + i) ? mem[row * 4096 + i] : 8'hff;
          loaded = i_dq == 8'h35;  // copy source stays editable
          fail = 0;
          busy_end = cyc + LOAD_CYC;
        end
        8'h10, 8'h11:
          if (loaded || i_dq == 8'h11)
          begin
            commit();  // lone 10h confirm starts nothing; 11h always commits
            gap = i_dq == 8'h11;
            busy_end = cyc + (gap ? DBSY_CYC : PROG_CYC);
          end
        8'hd0:
        begin
          ks.delete();
          foreach (mem[k]) if ((k >> 18) == (row >> 6)) ks.push_back(k);
          foreach (ks[j]) mem.delete(ks[j]);
          busy_end = cyc + PROG_CYC;
        end
        default: ;
      endcase
    end
    else if (i_ale)
    begin
      sh = cmd == 8'h60 ? an : an - 2;
      if (sh < 0) col = an == 0 ? i_dq : col | (i_dq & 8'h0f) << 8;
      else row = sh == 0 ? i_dq : row | i_dq << 8 * sh;
      an++;
    end
    else if (col < 2112)
    begin
      pbuf[col] = i_dq;
      col++;
      loaded = 1;
    end
endmodule // nand_flash_model

// *** verification/nand_host_seq_chk.sv ***
// port assertions for the nand host sequencer
// assumes pins are registered on i_clk; bound below
`timescale 1ns/1ns
module nand_host_seq_chk (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_req_valid,
  input wire logic       o_req_ready,
  input wire logic       o_rdata_valid,
  input wire logic [7:0] o_rdata,
  input wire logic       i_rdata_ready,
  input wire logic       o_done,
  input wire logic       o_fail,
  input wire logic       o_cle,
  input wire logic       o_ale,
  input wire logic       o_write_strobe_n,
  input wire logic       o_output_strobe_n,
  input wire logic [7:0] o_dq,
  input wire logic       o_dq_oe_n,
  input wire logic       i_ready_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence cmd_end;
    $rose(o_write_strobe_n) && $past(o_cle);
  endsequence
  latch_excl_a: assert property (!(o_cle && o_ale))
    else $error("cle and ale high together");
  write_drive_a: assert property (!o_write_strobe_n |-> o_output_strobe_n && !o_dq_oe_n)
    else $error("write cycle without driven data");
  read_float_a: assert property (!o_output_strobe_n |-> o_dq_oe_n && !o_cle && !o_ale)
    else $error("read cycle with data driven");
  strobe_width_a:
    assert property ($fell(o_write_strobe_n) |=> !o_write_strobe_n ##1 o_write_strobe_n)
    else $error("write strobe low not two cycles");
  busy_cmd_a:
    assert property ((!i_ready_busy) [*4] ##0 cmd_end |-> $past(o_dq) inside {8'h70, 8'hff})
    else $error("command other than status or reset while busy");
  take_drop_a: assert property (i_req_valid && o_req_ready |=> !o_req_ready)
    else $error("ready kept after a request was taken");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  hold_data_a:
    assert property (o_rdata_valid && !i_rdata_ready |=> o_rdata_valid && $stable(o_rdata))
    else $error("read byte lost under stall");
  cover property (o_done && o_fail);
  cover property (o_rdata_valid && !i_rdata_ready);
  cover property ((!i_ready_busy) [*4] ##0 cmd_end);
endmodule // nand_host_seq_chk

bind nand_host_seq nand_host_seq_chk chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
  .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata), .i_rdata_ready(i_rdata_ready),
  .o_done(o_done), .o_fail(o_fail), .o_cle(o_cle), .o_ale(o_ale),
  .o_write_strobe_n(o_write_strobe_n), .o_output_strobe_n(o_output_strobe_n),
  .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .i_ready_busy(i_ready_busy)
);
